// ===== design/port_cfg_consts.svh
`ifndef PORT_CFG_CONSTS_SVH
`define PORT_CFG_CONSTS_SVH
// register byte addresses (printed offsets 0xFA and 0xFB are not multiples of
// four, so they stand as indices and the byte address is four times the index)
`define SWAP_MASK_IDX        8'hFA
`define REMAP_PAIR_IDX       8'hFB
`define CTRL_IDX             8'hFC
`define STATUS_IDX           8'hFD
`define SWAP_MASK_ADDR       12'h3E8
`define REMAP_PAIR_ADDR      12'h3EC
`define CTRL_ADDR            12'h3F0
`define STATUS_ADDR          12'h3F4
// field positions and values
`define REMAP_P2_HI          7
`define REMAP_P2_LO          4
`define CTRL_MAP_EN_BIT      0
`define P2_DISABLED          4'h0
`define P2_MAX_LOGICAL       4'h7
`define PHYS_PORT2           3'h2
`define SWAP_MASK_RESET      8'h00
`define REMAP_PAIR_RESET     8'h00
`define CTRL_RESET           8'h00
`define NUM_PORTS            7
`endif

// ===== design/port_cfg_pkg.sv
package port_cfg_pkg;
    typedef logic [7:0] cfg_byte_t;
    typedef logic [2:0] port_num_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS
    } apb_state_t;
endpackage

// ===== design/pin_swap_cell.sv
`timescale 1ns/1ps
// one port's data pin pair, straight or crossed
module pin_swap_cell (
    input  wire logic swap_in,
    input  wire logic dplus_out_in,
    input  wire logic dminus_out_in,
    input  wire logic dplus_oe_in,
    input  wire logic dminus_oe_in,
    input  wire logic pos_pin_in,
    input  wire logic neg_pin_in,
    output logic      pos_pin_out,
    output logic      neg_pin_out,
    output logic      pos_pin_oe_out,
    output logic      neg_pin_oe_out,
    output logic      dplus_in_out,
    output logic      dminus_in_out
);
    // swap 0 keeps d+ on the positive pin, 1 crosses them
    always_comb begin
        pos_pin_out    = swap_in ? dminus_out_in : dplus_out_in;
        neg_pin_out    = swap_in ? dplus_out_in  : dminus_out_in;
        pos_pin_oe_out = swap_in ? dminus_oe_in  : dplus_oe_in;
        neg_pin_oe_out = swap_in ? dplus_oe_in   : dminus_oe_in;
        dplus_in_out   = swap_in ? neg_pin_in    : pos_pin_in;
        dminus_in_out  = swap_in ? pos_pin_in    : neg_pin_in;
    end
endmodule

// ===== design/port_swap_and_remap_config.sv
`timescale 1ns/1ps
`include "port_cfg_consts.svh"
module port_swap_and_remap_config (
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [7:0]  dplus_tx_in,
    input  wire logic [7:0]  dminus_tx_in,
    input  wire logic [7:0]  dplus_oe_in,
    input  wire logic [7:0]  dminus_oe_in,
    input  wire logic [7:0]  pos_pin_in,
    input  wire logic [7:0]  neg_pin_in,
    output logic      [7:0]  pos_pin_out,
    output logic      [7:0]  neg_pin_out,
    output logic      [7:0]  pos_pin_oe_out,
    output logic      [7:0]  neg_pin_oe_out,
    output logic      [7:0]  dplus_rx_out,
    output logic      [7:0]  dminus_rx_out,
    input  wire logic [2:0]  host_port_in,
    output logic      [2:0]  phys_port_out,
    output logic             host_port_valid_out,
    output logic      [2:0]  port2_logical_out,
    output logic             port2_enabled_out,
    output logic      [2:0]  port_count_out
);
    logic                    rst_s1_q;
    logic                    rst_n_q;
    port_cfg_pkg::cfg_byte_t swap_mask_q;
    port_cfg_pkg::cfg_byte_t remap_pair_q;
    port_cfg_pkg::cfg_byte_t ctrl_q;
    logic [31:0]             prdata_q;
    logic                    slverr_q;
    port_cfg_pkg::apb_state_t state_q;
    logic [3:0]              p2_field;
    logic                    map_en;
    logic                    p2_legal;
    logic [2:0]              p2_logical;
    logic                    hit_swap;
    logic                    hit_remap;
    logic                    hit_ctrl;
    logic                    hit_status;
    logic                    wr_ok;

    // every check below runs on the one clock and the synced reset
    default clocking cb_chk @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_q);

    // reset release through two flops, assert is immediate
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // decode; only full-word aligned addresses hit
    assign hit_swap   = (paddr_in == `SWAP_MASK_ADDR);
    assign hit_remap  = (paddr_in == `REMAP_PAIR_ADDR);
    assign hit_ctrl   = (paddr_in == `CTRL_ADDR);
    assign hit_status = (paddr_in == `STATUS_ADDR);
    assign wr_ok = psel_in && penable_in && pwrite_in && pstrb_in[0];

    // one wait-free access: pready high in every access phase
    assign pready_out  = (state_q == port_cfg_pkg::ST_ACCESS);
    assign pslverr_out = pready_out & slverr_q;
    assign prdata_out  = prdata_q;

    // setup phase tracker
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= port_cfg_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                port_cfg_pkg::ST_IDLE: begin
                    if (psel_in && !penable_in) begin
                        state_q <= port_cfg_pkg::ST_ACCESS;
                    end
                end
                port_cfg_pkg::ST_ACCESS: begin
                    state_q <= port_cfg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // read data and error captured in setup so they stand in access phase
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (psel_in && !penable_in) begin
            slverr_q <= !(hit_swap || hit_remap || hit_ctrl || hit_status)
                        || (pwrite_in && hit_status);
            prdata_q <= 32'h0000_0000;
            if (!pwrite_in) begin
                if (hit_swap) begin
                    prdata_q <= {24'h000000, swap_mask_q};
                end else if (hit_remap) begin
                    prdata_q <= {24'h000000, remap_pair_q};
                end else if (hit_ctrl) begin
                    prdata_q <= {24'h000000, ctrl_q};
                end else if (hit_status) begin
                    prdata_q <= {24'h0000_0, 1'b0, port_count_out,
                                 port2_enabled_out, port2_logical_out};
                end
            end
        end
    end

    // register writes land at the edge that completes the access
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            swap_mask_q  <= `SWAP_MASK_RESET;
            remap_pair_q <= `REMAP_PAIR_RESET;
            ctrl_q       <= `CTRL_RESET;
        end else if (wr_ok && pready_out) begin
            if (hit_swap) begin
                swap_mask_q <= pwdata_in[7:0];
            end
            if (hit_remap) begin
                remap_pair_q <= pwdata_in[7:0];
            end
            if (hit_ctrl) begin
                ctrl_q <= pwdata_in[7:0];
            end
        end
    end

    // per-port pin swap; bit n steers port n, bit 0 the upstream port
    genvar g;
    for (g = 0; g < 8; g++) begin : g_swap
        pin_swap_cell u_cell (
            .swap_in       (swap_mask_q[g]),
            .dplus_out_in  (dplus_tx_in[g]),
            .dminus_out_in (dminus_tx_in[g]),
            .dplus_oe_in   (dplus_oe_in[g]),
            .dminus_oe_in  (dminus_oe_in[g]),
            .pos_pin_in    (pos_pin_in[g]),
            .neg_pin_in    (neg_pin_in[g]),
            .pos_pin_out   (pos_pin_out[g]),
            .neg_pin_out   (neg_pin_out[g]),
            .pos_pin_oe_out(pos_pin_oe_out[g]),
            .neg_pin_oe_out(neg_pin_oe_out[g]),
            .dplus_in_out  (dplus_rx_out[g]),
            .dminus_in_out (dminus_rx_out[g])
        );
    end

    // port 2 remap decode; reserved codes fall back to disabled
    assign map_en   = ctrl_q[`CTRL_MAP_EN_BIT];
    assign p2_field = remap_pair_q[`REMAP_P2_HI:`REMAP_P2_LO];
    assign p2_legal = (p2_field != `P2_DISABLED)
                      && (p2_field <= `P2_MAX_LOGICAL);
    assign p2_logical = p2_field[2:0];

    // logical view of port 2; without mapping it keeps its own number
    always_comb begin
        if (map_en) begin
            port2_enabled_out = p2_legal;
            port2_logical_out = p2_legal ? p2_logical : 3'h0;
        end else begin
            port2_enabled_out = 1'b1;
            port2_logical_out = `PHYS_PORT2;
        end
    end

    // only a count goes out for enumeration, never a numbering
    assign port_count_out = (map_en && !p2_legal)
                            ? 3'(`NUM_PORTS - 1) : 3'(`NUM_PORTS);

    // host port numbers are logical; translate back for port 2 only
    // since the other remap fields are not decoded here
    always_comb begin
        phys_port_out       = host_port_in;
        host_port_valid_out = (host_port_in != 3'h0);
        if (map_en && p2_legal && host_port_in == p2_logical) begin
            phys_port_out = `PHYS_PORT2;
        end
    end

    // a field of 0001 must surface as logical port 1
    AST_P2_ONE: assert property (
        (map_en && p2_field == 4'h1) |-> port2_logical_out == 3'h1)
        else $error("port 2 not at logical 1");
    // reserved field leaves port 2 disabled
    AST_P2_RSVD: assert property (
        (map_en && p2_field[3]) |-> !port2_enabled_out)
        else $error("reserved remap not disabled");
    AST_P2_ZERO: assert property (
        (map_en && p2_field == 4'h0) |-> !port2_enabled_out)
        else $error("zero field did not disable");
    AST_P2_EQ: assert property (
        (map_en && p2_field >= 4'h2 && p2_field <= 4'h7)
        |-> port2_logical_out == p2_field[2:0])
        else $error("logical number differs from field");
    AST_NOMAP: assert property (
        !map_en |-> port2_logical_out == 3'h2 && port2_enabled_out)
        else $error("mapping active while disabled");
    AST_TRANSLATE: assert property (
        (!map_en) |-> phys_port_out == host_port_in)
        else $error("translation without map enable");
    AST_STRAIGHT: assert property (
        !swap_mask_q[5] |-> pos_pin_out[5] == dplus_tx_in[5])
        else $error("port 5 d+ not on positive pin");
    AST_CROSSED: assert property (
        swap_mask_q[7] |-> neg_pin_out[7] == dplus_tx_in[7]
        && pos_pin_out[7] == dminus_tx_in[7])
        else $error("port 7 pins not crossed");
    sequence swap_write_s;
        psel_in && penable_in && pready_out && pwrite_in && hit_swap
        && pstrb_in[0];
    endsequence
    AST_MASK_WR: assert property (
        swap_write_s |=> swap_mask_q == $past(pwdata_in[7:0]))
        else $error("swap mask not written");
    AST_COUNT: assert property (
        port_count_out == ((map_en && !p2_legal) ? 3'h6 : 3'h7))
        else $error("port count wrong");
endmodule

// ===== tb/host_port_model.sv
`timescale 1ns/1ps
// host side: walks logical port numbers 1..reported count, one per clock
module host_port_model (
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic [2:0] port_count_in,
    output logic      [2:0] host_port_out
);
    // numbering restarts at one once the reported count is reached
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            host_port_out <= 3'h1;
        end else if (host_port_out >= port_count_in) begin
            host_port_out <= 3'h1;
        end else begin
            host_port_out <= host_port_out + 3'h1;
        end
    end
endmodule

// ===== tb/port_swap_and_remap_config_test.sv
`timescale 1ns/1ps
module port_swap_and_remap_config_test;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  dp = 8'h00, dm = 8'h00, dpo = 8'h00, dmo = 8'h00;
    logic [7:0]  pin_p = 8'h00, pin_n = 8'h00;
    logic [7:0]  po, no, poe, noe, rxp, rxn, s;
    logic [31:0] prdata, r;
    logic        pready, pslverr, hvalid, p2_en, e;
    logic [2:0]  host, phys, p2_log, cnt;
    logic        m = 1'b0, mon = 1'b0;
    logic [3:0]  f = 4'h0;
    int          errors = 0, cmp_count = 0;

    // 125 MHz
    always #4 mclk = ~mclk;

    port_swap_and_remap_config i_dut (
        .mclk_in(mclk), .reset_n_in(reset_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .dplus_tx_in(dp),
        .dminus_tx_in(dm), .dplus_oe_in(dpo), .dminus_oe_in(dmo),
        .pos_pin_in(pin_p), .neg_pin_in(pin_n), .pos_pin_out(po),
        .neg_pin_out(no), .pos_pin_oe_out(poe), .neg_pin_oe_out(noe),
        .dplus_rx_out(rxp), .dminus_rx_out(rxn), .host_port_in(host),
        .phys_port_out(phys), .host_port_valid_out(hvalid),
        .port2_logical_out(p2_log), .port2_enabled_out(p2_en),
        .port_count_out(cnt));

    host_port_model i_host (.mclk_in(mclk), .reset_n_in(reset_n),
        .port_count_in(cnt), .host_port_out(host));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // one apb transfer; answer taken at the edge where pready is seen
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int   n;
        logic rdy;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // no wait count assumed: only the watchdog ends a stuck transfer
        do begin
            @(posedge mclk);
            rdy = pready;
            r = prdata;
            e = pslverr;
            n++;
        end while (rdy !== 1'b1);
        chk(n, 1); // zero wait states expected
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] xs(logic [7:0] a, b, sw);
        return (a & ~sw) | (b & sw);
    endfunction

    function automatic logic en_f();
        return !m || (f != 4'h0 && !f[3]);
    endfunction

    function automatic logic [2:0] lg_f();
        return !en_f() ? 3'h0 : (m ? f[2:0] : 3'h2);
    endfunction

    function automatic logic [7:0] est();
        return {1'b0, en_f() ? 3'h7 : 3'h6, en_f(), lg_f()};
    endfunction

    // host traffic checked at mid-cycle, paused while settings change
    always @(negedge mclk) begin
        if (mon) begin
            chk(phys, (m && en_f() && host == f[2:0]) ? 3'h2 : host);
            chk(hvalid, 1'b1);
            chk(cnt, en_f() ? 3'h7 : 3'h6);
            chk(p2_log, lg_f());
        end
    end

    initial begin
        void'($urandom(32'h0DA9581C));
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        apb(1'b0, 12'h3E8, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 12'h3F4, 32'h0);
        chk(r, 32'h7A);
        apb(1'b0, 12'h3F8, 32'h0);
        chk(e, 1'b1);
        chk(r, 32'h0);
        apb(1'b1, 12'h3F4, 32'hFF);
        chk(e, 1'b1);
        // all-clear and all-set masks first, then random ones
        for (int i = 0; i < 12; i++) begin
            s = i == 0 ? 8'h00 : (i == 1 ? 8'hFF : 8'($urandom));
            apb(1'b1, 12'h3E8, {24'h0, s});
            {dp, dm, dpo, dmo} <= $urandom;
            {pin_p, pin_n} <= 16'($urandom);
            @(negedge mclk);
            chk(po, xs(dp, dm, s));
            chk(no, xs(dm, dp, s));
            chk(poe, xs(dpo, dmo, s));
            chk(noe, xs(dmo, dpo, s));
            chk(rxp, xs(pin_p, pin_n, s));
            chk(rxn, xs(pin_n, pin_p, s));
        end
        // masked lane write must leave the mask alone, with no error
        @(posedge mclk);
        pstrb <= 4'h0;
        apb(1'b1, 12'h3E8, {24'h0, ~s});
        chk(e, 1'b0);
        pstrb <= 4'hF;
        apb(1'b0, 12'h3E8, 32'h0);
        chk(r, {24'h0, s});
        // every field value, map off then on
        for (int i = 0; i < 32; i++) begin
            mon = 1'b0;
            m = i[4];
            f = i[3:0];
            apb(1'b1, 12'h3F0, {31'h0, m});
            // port 1 nibble is not decoded here, filler only
            apb(1'b1, 12'h3EC, {24'h0, f, 4'($urandom)});
            apb(1'b0, 12'h3F4, 32'h0);
            chk(r, {24'h0, est()});
            chk(p2_en, en_f());
            mon = 1'b1;
            repeat (8) @(posedge mclk);
        end
        conclude;
    end

    // far beyond the expected run of under a thousand cycles
    initial begin
        #200000;
        errors++;
        conclude;
    end
endmodule
